// [pkg/opt_loader_pkg.sv]
// constants shared by the startup option loader and its testbench
// How it works
// - at every reset exit, read option bytes 0080H..0084H and apply them
// - with boot swap active, read the copy at 1080H..1084H instead
// - first byte gives watchdog interval, run-at-reset and window period
// - first byte bit 0 set keeps low-speed oscillator running always
// - detector default on: hold reset until supply above 1.91 V
// - detector default off: hold reset until supply above 1.61 V
// - second option byte writable only by external programmer, never self-programming
// - third byte picks high-speed oscillator 4 MHz or 8 MHz
// - fourth byte picks which pin pair carries debug clock and data
// - fifth byte picks debug off, on with erase, on without erase
// - erase mode: erase flash when debug security id check fails
// - second byte bit 0 one turns detector on at power-up
// - watchdog run bit enables counting and illegal-access detection together
// - debug field 00 off, 10 on, 11 on with erase, 01 prohibited
package opt_loader_pkg;
  // ************************************************************
  // option byte area
  // ************************************************************
  localparam logic [15:0] OPT_BASE_PRI = 16'h0080;
  localparam logic [15:0] OPT_BASE_ALT = 16'h1080;
  localparam logic [2:0] OPT_LAST_IDX = 3'h4;
  localparam logic [2:0] IDX_WDT = 3'h0;
  localparam logic [2:0] IDX_LVD = 3'h1;
  localparam logic [2:0] IDX_HSO = 3'h2;
  localparam logic [2:0] IDX_PIN = 3'h3;
  localparam logic [2:0] IDX_DBG = 3'h4;
  // field positions
  localparam int LSOSC_BIT = 0;
  localparam int WDT_CS_LSB = 1;
  localparam int WDT_RUN_BIT = 4;
  localparam int WDT_WIN_LSB = 5;
  localparam int LVD_ON_BIT = 0;
  localparam int HSO_4M_BIT = 0;
  localparam int PIN_A_BIT = 1;
  localparam int DBG_LSB = 0;
  // debug control codes
  localparam logic [1:0] DBG_OFF = 2'h0;
  localparam logic [1:0] DBG_BAD = 2'h1;
  localparam logic [1:0] DBG_KEEP = 2'h2;
  localparam logic [1:0] DBG_ERASE = 2'h3;
  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_BYTE0 = 8'h04;
  localparam logic [7:0] REG_CTRL = 8'h18;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [3:0] CTRL_RESET = 4'h0;
  // loader states, gray along req, wait, hold, run
  typedef enum logic [1:0]
  {
    LD_REQ = 2'b00,
    LD_WAIT = 2'b01,
    LD_HOLD = 2'b11,
    LD_RUN = 2'b10
  } load_state_type;
endpackage

// [pkg/opt_store_if.sv]
// carrier between the loader and its option byte store
`timescale 1ns/1ns
interface opt_store_if;
  logic wr_en;
  logic [2:0] wr_idx;
  logic [7:0] wr_data;
  logic [2:0] rd_idx;
  logic [7:0] rd_data;
  modport loader (output wr_en, output wr_idx, output wr_data, output rd_idx, input rd_data);
  modport store (input wr_en, input wr_idx, input wr_data, input rd_idx, output rd_data);
endinterface

// [verilog/opt_byte_store.sv]
// five-byte store holding the raw option bytes, registered read port
`timescale 1ns/1ns
module opt_byte_store
#(
  parameter int DEPTH = 5
)
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  opt_store_if.store bus
);
  logic [7:0] mem_q [DEPTH];
  logic [7:0] rd_q;

  // ************************************************************
  // storage
  // ************************************************************
  // bytes are written once per reset by the loader
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      for (int i = 0; i < DEPTH; i++)
        mem_q[i] <= 8'h00;
    end
    else if (bus.wr_en && (32'(bus.wr_idx) < DEPTH))
      mem_q[bus.wr_idx] <= bus.wr_data;
  end

  // read data from a register; out of range reads as zero
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
      rd_q <= 8'h00;
    else if (32'(bus.rd_idx) < DEPTH)
      rd_q <= mem_q[bus.rd_idx];
    else
      rd_q <= 8'h00;
  end

  assign bus.rd_data = rd_q;
endmodule

// [verilog/startup_option_loader.sv]
// startup option loader: reads option bytes at reset exit and drives the settings
`timescale 1ns/1ns
module startup_option_loader
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [15:0] flash_addr_out,
  output logic flash_rd_out,
  input wire logic [7:0] flash_data_in,
  input wire logic flash_valid_in,
  input wire logic boot_swap_in,
  input wire logic por_above_in,
  input wire logic lvd_above_in,
  input wire logic auth_fail_in,
  input wire logic prog_wr_in,
  input wire logic [15:0] prog_wr_addr_in,
  input wire logic programmer_active_in,
  output logic wr_allow_out,
  output logic sys_rst_n_out,
  output logic lsosc_stop_allow_out,
  output logic lsosc_run_out,
  output logic [2:0] wdt_interval_out,
  output logic watchdog_run_at_reset_out,
  output logic illegal_access_det_out,
  output logic [1:0] wdt_window_out,
  output logic detector_default_on_out,
  output logic hs_osc_4mhz_out,
  output logic debug_pin_a_sel_out,
  output logic debug_en_out,
  output logic [1:0] debug_mode_out,
  output logic flash_erase_out
);
  opt_loader_pkg::load_state_type state_q;
  logic [2:0] idx_q;
  logic swap_q;
  logic rst_rel_q;
  logic [7:0] wdt_byte_q;
  logic lvd_on_q;
  logic hso_q;
  logic pin_q;
  logic [1:0] dbg_q;
  logic [15:0] faddr_q;
  logic frd_q;
  logic wr_allow_q;
  logic erase_q;
  logic [3:0] ctrl_q;
  logic lsosc_run_q;
  logic awr_q, wr_q, bv_q, arr_q, rv_q;
  logic [1:0] bresp_q, rresp_q;
  logic aw_held_q, w_held_q;
  logic [7:0] awaddr_q, araddr_q;
  logic [31:0] wdata_q, rdata_q;
  logic [3:0] wstrb_q;
  logic [1:0] rd_ph_q;
  opt_store_if store_bus ();

  // option byte address for a given copy and byte index
  function automatic logic [15:0] opt_addr(input logic alt, input logic [2:0] idx);
    opt_addr = (alt ? opt_loader_pkg::OPT_BASE_ALT : opt_loader_pkg::OPT_BASE_PRI)
      + {13'h0000, idx};
  endfunction

  // ************************************************************
  // loader sequence
  // ************************************************************
  // one byte at a time; the reset stays held until all five are in
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      state_q <= opt_loader_pkg::LD_REQ;
      idx_q <= 3'h0;
      frd_q <= 1'b0;
      faddr_q <= 16'h0000;
      rst_rel_q <= 1'b0;
    end
    else
    begin
      case (state_q)
        opt_loader_pkg::LD_REQ:
        begin
          faddr_q <= opt_addr(idx_q == 3'h0 ? boot_swap_in : swap_q, idx_q);
          frd_q <= 1'b1;
          state_q <= opt_loader_pkg::LD_WAIT;
        end
        opt_loader_pkg::LD_WAIT:
          if (flash_valid_in)
          begin
            frd_q <= 1'b0;
            idx_q <= idx_q + 3'h1;
            if (idx_q == opt_loader_pkg::OPT_LAST_IDX)
              state_q <= opt_loader_pkg::LD_HOLD;
            else
              state_q <= opt_loader_pkg::LD_REQ;
          end
        opt_loader_pkg::LD_HOLD:
          // release threshold follows the detector default bit
          if (lvd_on_q ? lvd_above_in : por_above_in)
          begin
            state_q <= opt_loader_pkg::LD_RUN;
            rst_rel_q <= 1'b1;
          end
        opt_loader_pkg::LD_RUN:
          state_q <= opt_loader_pkg::LD_RUN;
        default:
          state_q <= opt_loader_pkg::LD_REQ;
      endcase
    end
  end

  // boot swap is caught with the first request only, so one pass never mixes copies
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
      swap_q <= 1'b0;
    else if (state_q == opt_loader_pkg::LD_REQ && idx_q == 3'h0)
      swap_q <= boot_swap_in;
  end

  // decode each byte as it arrives; nothing changes after the load
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      wdt_byte_q <= 8'h01; // bit 0 set: no oscillator stop before byte 0 arrives
      lvd_on_q <= 1'b0;
      hso_q <= 1'b0;
      pin_q <= 1'b0;
      dbg_q <= opt_loader_pkg::DBG_OFF;
    end
    else if (state_q == opt_loader_pkg::LD_WAIT && flash_valid_in)
    begin
      case (idx_q)
        opt_loader_pkg::IDX_WDT: wdt_byte_q <= flash_data_in;
        opt_loader_pkg::IDX_LVD: lvd_on_q <= flash_data_in[opt_loader_pkg::LVD_ON_BIT];
        opt_loader_pkg::IDX_HSO: hso_q <= flash_data_in[opt_loader_pkg::HSO_4M_BIT];
        opt_loader_pkg::IDX_PIN: pin_q <= flash_data_in[opt_loader_pkg::PIN_A_BIT];
        opt_loader_pkg::IDX_DBG: dbg_q <= flash_data_in[opt_loader_pkg::DBG_LSB +: 2];
        default: dbg_q <= dbg_q;
      endcase
    end
  end

  assign store_bus.wr_en = (state_q == opt_loader_pkg::LD_WAIT) && flash_valid_in;
  assign store_bus.wr_idx = idx_q;
  assign store_bus.wr_data = flash_data_in;
  assign store_bus.rd_idx = 3'(araddr_q[7:2] - 6'h01);

  opt_byte_store #(.DEPTH(5)) u_store
  (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .bus(store_bus)
  );

  // ************************************************************
  // protection, erase and oscillator
  // ************************************************************
  // the detector default byte is locked against self-programming in either copy
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
      wr_allow_q <= 1'b0;
    else
      wr_allow_q <= prog_wr_in && (programmer_active_in ||
        (prog_wr_addr_in != opt_addr(1'b0, opt_loader_pkg::IDX_LVD) &&
         prog_wr_addr_in != opt_addr(1'b1, opt_loader_pkg::IDX_LVD)));
  end

  // failed id check erases only in erase mode, and only once running
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
      erase_q <= 1'b0;
    else
      erase_q <= auth_fail_in && rst_rel_q && dbg_q == opt_loader_pkg::DBG_ERASE;
  end

  // stop request from software is ignored when the option forbids stopping
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
      lsosc_run_q <= 1'b1;
    else
      lsosc_run_q <= !(ctrl_q[0] && !wdt_byte_q[opt_loader_pkg::LSOSC_BIT]);
  end

  // ************************************************************
  // register bus
  // ************************************************************
  // address and data are taken in either order, response after both
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      awr_q <= 1'b1;
      wr_q <= 1'b1;
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      bv_q <= 1'b0;
      bresp_q <= opt_loader_pkg::RESP_OKAY;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      ctrl_q <= opt_loader_pkg::CTRL_RESET;
    end
    else
    begin
      if (s_axi_awvalid && awr_q)
      begin
        awaddr_q <= s_axi_awaddr;
        aw_held_q <= 1'b1;
        awr_q <= 1'b0;
      end
      if (s_axi_wvalid && wr_q)
      begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        w_held_q <= 1'b1;
        wr_q <= 1'b0;
      end
      if (aw_held_q && w_held_q && !bv_q)
      begin
        bv_q <= 1'b1;
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        if (awaddr_q == opt_loader_pkg::REG_CTRL)
        begin
          bresp_q <= opt_loader_pkg::RESP_OKAY;
          if (wstrb_q[0])
            ctrl_q <= wdata_q[3:0];
        end
        else if (awaddr_q[1:0] == 2'h0 && awaddr_q < opt_loader_pkg::REG_CTRL)
          bresp_q <= opt_loader_pkg::RESP_OKAY; // read-only, write dropped
        else
          bresp_q <= opt_loader_pkg::RESP_SLVERR;
      end
      if (bv_q && s_axi_bready)
      begin
        bv_q <= 1'b0;
        awr_q <= 1'b1;
        wr_q <= 1'b1;
      end
    end
  end

  // reads wait one cycle for the store's registered data
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      arr_q <= 1'b1;
      rv_q <= 1'b0;
      rd_ph_q <= 2'h0;
      araddr_q <= 8'h00;
      rdata_q <= 32'h00000000;
      rresp_q <= opt_loader_pkg::RESP_OKAY;
    end
    else
    begin
      if (s_axi_arvalid && arr_q)
      begin
        araddr_q <= s_axi_araddr;
        arr_q <= 1'b0;
        rd_ph_q <= 2'h1;
      end
      else if (rd_ph_q == 2'h1)
        rd_ph_q <= 2'h2;
      else if (rd_ph_q == 2'h2)
      begin
        rd_ph_q <= 2'h0;
        rv_q <= 1'b1;
        rresp_q <= opt_loader_pkg::RESP_OKAY;
        if (araddr_q == opt_loader_pkg::REG_STATUS)
          rdata_q <= {27'h0000000, dbg_q == opt_loader_pkg::DBG_BAD, swap_q, rst_rel_q,
            state_q == opt_loader_pkg::LD_HOLD || state_q == opt_loader_pkg::LD_RUN, 1'b0};
        else if (araddr_q == opt_loader_pkg::REG_CTRL)
          rdata_q <= {28'h0000000, ctrl_q};
        else if (araddr_q[1:0] == 2'h0 && araddr_q < opt_loader_pkg::REG_CTRL)
          rdata_q <= {24'h000000, store_bus.rd_data};
        else
        begin
          rdata_q <= 32'h00000000;
          rresp_q <= opt_loader_pkg::RESP_SLVERR;
        end
      end
      if (rv_q && s_axi_rready)
      begin
        rv_q <= 1'b0;
        arr_q <= 1'b1;
      end
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign s_axi_awready = awr_q;
  assign s_axi_wready = wr_q;
  assign s_axi_bvalid = bv_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arr_q;
  assign s_axi_rvalid = rv_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign flash_addr_out = faddr_q;
  assign flash_rd_out = frd_q;
  assign wr_allow_out = wr_allow_q;
  assign sys_rst_n_out = rst_rel_q;
  assign lsosc_stop_allow_out = !wdt_byte_q[opt_loader_pkg::LSOSC_BIT];
  assign lsosc_run_out = lsosc_run_q;
  assign wdt_interval_out = wdt_byte_q[opt_loader_pkg::WDT_CS_LSB +: 3];
  assign watchdog_run_at_reset_out = wdt_byte_q[opt_loader_pkg::WDT_RUN_BIT];
  assign illegal_access_det_out = wdt_byte_q[opt_loader_pkg::WDT_RUN_BIT];
  assign wdt_window_out = wdt_byte_q[opt_loader_pkg::WDT_WIN_LSB +: 2];
  assign detector_default_on_out = lvd_on_q;
  assign hs_osc_4mhz_out = hso_q;
  assign debug_pin_a_sel_out = pin_q;
  // prohibited code 01 is treated as debug off
  assign debug_en_out = dbg_q[1];
  assign debug_mode_out = dbg_q;
  assign flash_erase_out = erase_q;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  chk_release_after_load: assert property (sys_rst_n_out |-> state_q == opt_loader_pkg::LD_RUN)
    else $error("reset released before load done");
  chk_pri_address: assert property (flash_rd_out && !swap_q |-> flash_addr_out[15:3] == 13'h0010)
    else $error("primary read outside option area");
  chk_alt_address: assert property (flash_rd_out && swap_q |-> flash_addr_out[15:3] == 13'h0210)
    else $error("swap read outside alternate area");
  chk_lvd_hold: assert property (state_q == opt_loader_pkg::LD_HOLD && lvd_on_q && !lvd_above_in
    |=> !sys_rst_n_out)
    else $error("released below detector level");
  chk_por_release: assert property (state_q == opt_loader_pkg::LD_HOLD && !lvd_on_q && por_above_in
    |=> sys_rst_n_out)
    else $error("not released above power-on level");
  chk_lvd_byte_lock: assert property (prog_wr_in && !programmer_active_in &&
    prog_wr_addr_in == 16'h0081 |=> !wr_allow_out)
    else $error("detector byte writable by self-programming");
  chk_erase_cause: assert property (flash_erase_out |-> $past(dbg_q) == 2'h3 && $past(auth_fail_in))
    else $error("erase without erase mode failure");
  chk_erase_on_fail: assert property (sys_rst_n_out && auth_fail_in && debug_mode_out == 2'h3
    |=> flash_erase_out)
    else $error("missed erase on id failure");
  chk_settings_stable: assert property (sys_rst_n_out |=> $stable(wdt_byte_q) && $stable(dbg_q)
    && $stable(sys_rst_n_out))
    else $error("settings changed after release");
  chk_lsosc_kept: assert property (sys_rst_n_out && !lsosc_stop_allow_out |=> lsosc_run_out)
    else $error("oscillator stopped though forbidden");
  chk_wdt_pair: assert property (watchdog_run_at_reset_out == illegal_access_det_out)
    else $error("watchdog run and detect differ");

  cov_swap_load: cover property (swap_q && sys_rst_n_out);
  cov_erase_event: cover property (flash_erase_out);
  cov_lvd_release: cover property (lvd_on_q && $rose(sys_rst_n_out));
endmodule

// [test/flash_option_model.sv]
// flash array model that answers option byte reads, promptly or slowly
`timescale 1ns/1ns
module flash_option_model
(
  input wire logic clk_in,
  input wire logic [15:0] flash_addr_out,
  input wire logic flash_rd_out,
  input wire logic [39:0] image_in,
  input wire logic [3:0] delay_in,
  output logic [7:0] flash_data_in,
  output logic flash_valid_in
);
  logic [3:0] wait_q = 4'h0;
  logic hit;
  // one image serves both copies, so a swapped boot reads the same bytes
  assign hit = (flash_addr_out[15:3] == 13'h0010 || flash_addr_out[15:3] == 13'h0210)
    && flash_addr_out[2:0] < 3'h5;
  initial flash_data_in = 8'h00;
  initial flash_valid_in = 1'b0;
  // valid for one cycle after the delay; data toggles otherwise so stale bytes never pass
  always @(posedge clk_in)
  begin
    if (flash_rd_out && !flash_valid_in && wait_q >= delay_in && hit)
    begin
      flash_valid_in <= 1'b1;
      flash_data_in <= image_in[8 * flash_addr_out[2:0] +: 8];
      wait_q <= 4'h0;
    end
    else
    begin
      flash_valid_in <= 1'b0;
      flash_data_in <= ~flash_data_in;
      wait_q <= (flash_rd_out && !flash_valid_in) ? wait_q + 4'h1 : wait_q;
    end
  end
endmodule

// [test/startup_option_loader_tb.sv]
// self-checking bench for the startup option loader
`timescale 1ns/1ns
module startup_option_loader_tb;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [7:0] s_axi_awaddr, s_axi_araddr, flash_data_in;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb, delay;
  logic [1:0] s_axi_bresp, s_axi_rresp, wdt_window_out, debug_mode_out;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [15:0] flash_addr_out, prog_wr_addr_in;
  logic flash_rd_out, flash_valid_in, boot_swap_in, por_above_in, lvd_above_in;
  logic auth_fail_in, prog_wr_in, programmer_active_in, wr_allow_out, sys_rst_n_out;
  logic lsosc_stop_allow_out, lsosc_run_out, watchdog_run_at_reset_out;
  logic illegal_access_det_out, detector_default_on_out, hs_osc_4mhz_out;
  logic debug_pin_a_sel_out, debug_en_out, flash_erase_out;
  logic [2:0] wdt_interval_out;
  logic [39:0] image;
  logic pw_q = 1'b0;
  logic [33:0] rq[$], bq[$], aq[$], fq[$];
  int miscompares = 0;
  int n_compared = 0;
  // ************************************************************
  // design, flash model, clock
  // ************************************************************
  startup_option_loader i_startup_option_loader
  (
    .clk_in, .rst_n_in, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .flash_addr_out, .flash_rd_out, .flash_data_in,
    .flash_valid_in, .boot_swap_in, .por_above_in, .lvd_above_in, .auth_fail_in,
    .prog_wr_in, .prog_wr_addr_in, .programmer_active_in, .wr_allow_out, .sys_rst_n_out,
    .lsosc_stop_allow_out, .lsosc_run_out, .wdt_interval_out, .watchdog_run_at_reset_out,
    .illegal_access_det_out, .wdt_window_out, .detector_default_on_out, .hs_osc_4mhz_out,
    .debug_pin_a_sel_out, .debug_en_out, .debug_mode_out, .flash_erase_out
  );
  flash_option_model i_flash_option_model
  (
    .clk_in, .flash_addr_out, .flash_rd_out, .image_in(image), .delay_in(delay),
    .flash_data_in, .flash_valid_in
  );
  // 50 MHz
  always #10 clk_in = ~clk_in;
  // ************************************************************
  // helpers
  // ************************************************************
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("compared %0d, miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // settings outputs packed in one word, and the same word built from the image
  function automatic logic [33:0] cfg_got();
    return 34'({lsosc_stop_allow_out, wdt_interval_out, watchdog_run_at_reset_out,
      illegal_access_det_out, wdt_window_out, detector_default_on_out, hs_osc_4mhz_out,
      debug_pin_a_sel_out, debug_en_out, debug_mode_out});
  endfunction
  function automatic logic [33:0] cfg_exp(input logic [39:0] m);
    return 34'({~m[0], m[3:1], m[4], m[4], m[6:5], m[8], m[16], m[25], m[33], m[33:32]});
  endfunction
  task automatic push_addrs(input logic [15:0] b);
    fq.delete();
    for (int i = 0; i < 5; i++)
      fq.push_back(34'(b + 16'(i)));
  endtask
  // write: address and data offered together, each dropped when taken
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    bq.push_back(34'(r));
    @(posedge clk_in);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk_in);
      n++;
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid && n < 60);
    s_axi_bready <= 1'b0;
  endtask
  task automatic bus_rd(input logic [7:0] a, input logic [33:0] e);
    int n;
    rq.push_back(e);
    @(posedge clk_in);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk_in);
      n++;
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid && n < 60);
    s_axi_rready <= 1'b0;
  endtask
  // result watcher: pops the oldest note whenever a result shows at the ports
  always @(posedge clk_in)
  begin
    if (s_axi_rvalid && s_axi_rready)
      chk({s_axi_rresp, s_axi_rdata}, rq.pop_front());
    if (s_axi_bvalid && s_axi_bready)
      chk(34'(s_axi_bresp), bq.pop_front());
    if (pw_q)
      chk(34'(wr_allow_out), aq.pop_front());
    if (fq.size() > 0)
      chk(34'(sys_rst_n_out), 34'h0);
    if (flash_rd_out && flash_valid_in)
      chk(34'(flash_addr_out), (fq.size() > 0) ? fq.pop_front() : 34'h3dead);
    pw_q <= prog_wr_in;
  end
  // hang guard, far beyond four boots of traffic
  initial
  begin
    tick(20000);
    miscompares++;
    print_verdict();
  end
  // four boots: swap, detector option and debug code differ in each
  initial
  begin
    logic [39:0] m;
    logic [15:0] base, pa;
    logic [31:0] d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {boot_swap_in, por_above_in, lvd_above_in, auth_fail_in, prog_wr_in} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, prog_wr_addr_in, image, delay} = '0;
    programmer_active_in = 1'b0;
    s_axi_wstrb = 4'hf;
    void'($urandom(32'h95ec));
    for (int run = 0; run < 4; run++)
    begin
      m = {8'($urandom), 32'($urandom)};
      m[33:32] = 2'(run);
      m[8] = run[1];
      base = run[0] ? opt_loader_pkg::OPT_BASE_ALT : opt_loader_pkg::OPT_BASE_PRI;
      @(posedge clk_in);
      image <= m;
      delay <= 4'($urandom % 8);
      rst_n_in <= 1'b0;
      boot_swap_in <= run[0];
      por_above_in <= (run == 1 || run == 2);
      lvd_above_in <= (run == 1 || run == 2);
      tick(run == 0 ? 8 : 2);
      chk(cfg_got(), 34'h0);
      chk(34'(lsosc_run_out), 34'h1);
      // reset again in mid-load: the load must start over
      if (run == 2)
      begin
        push_addrs(base);
        rst_n_in <= 1'b1;
        tick(4);
        rst_n_in <= 1'b0;
        tick(2);
      end
      push_addrs(base);
      rst_n_in <= 1'b1;
      for (int n = 0; n < 200 && fq.size() > 0; n++)
        tick(1);
      tick(4);
      if (run == 0 || run == 3)
      begin
        por_above_in <= run[0];
        lvd_above_in <= !run[0];
        tick(5);
        chk(34'(sys_rst_n_out), 34'h0);
        por_above_in <= 1'b1;
        lvd_above_in <= 1'b1;
        tick(2);
      end
      chk(34'(sys_rst_n_out), 34'h1);
      boot_swap_in <= !run[0];
      chk(cfg_got(), cfg_exp(m));
      bus_rd(opt_loader_pkg::REG_STATUS,
        34'({m[33:32] == opt_loader_pkg::DBG_BAD, run[0], 3'h6}));
      bus_rd(opt_loader_pkg::REG_CTRL, 34'(opt_loader_pkg::CTRL_RESET));
      for (int i = 0; i < 5; i++)
        bus_rd(opt_loader_pkg::REG_BYTE0 + 8'(4 * i), 34'(m[8 * i +: 8]));
      bus_wr(opt_loader_pkg::REG_BYTE0, $urandom, opt_loader_pkg::RESP_OKAY);
      bus_rd(opt_loader_pkg::REG_BYTE0, 34'(m[7:0]));
      bus_wr(8'h20, $urandom, opt_loader_pkg::RESP_SLVERR);
      bus_rd(8'h1c, {opt_loader_pkg::RESP_SLVERR, 32'h0});
      d = $urandom;
      bus_wr(opt_loader_pkg::REG_CTRL, d, opt_loader_pkg::RESP_OKAY);
      bus_rd(opt_loader_pkg::REG_CTRL, 34'(d[3:0]));
      // stop request only bites when the first byte allows stopping
      bus_wr(opt_loader_pkg::REG_CTRL, 32'h1, opt_loader_pkg::RESP_OKAY);
      tick(2);
      chk(34'(lsosc_run_out), 34'(m[0]));
      bus_wr(opt_loader_pkg::REG_CTRL, 32'h0, opt_loader_pkg::RESP_OKAY);
      tick(2);
      chk(34'(lsosc_run_out), 34'h1);
      auth_fail_in <= 1'b1;
      tick(1);
      auth_fail_in <= 1'b0;
      tick(1);
      chk(34'(flash_erase_out), 34'(run == 3));
      tick(1);
      chk(34'(flash_erase_out), 34'h0);
      // back-to-back flash write attempts against both copies of the second byte
      for (int i = 0; i < 5; i++)
      begin
        pa = (i == 4) ? 16'($urandom) : (i[0] ? 16'h1081 : 16'h0081);
        prog_wr_in <= 1'b1;
        prog_wr_addr_in <= pa;
        programmer_active_in <= i[1];
        aq.push_back(34'(i[1] || (pa != 16'h0081 && pa != 16'h1081)));
        tick(1);
      end
      prog_wr_in <= 1'b0;
      por_above_in <= 1'b0;
      lvd_above_in <= 1'b0;
      tick(3);
      chk(34'(sys_rst_n_out), 34'h1);
      chk(cfg_got(), cfg_exp(m));
    end
    tick(4);
    chk(34'(rq.size() + bq.size() + aq.size()), 34'h0);
    print_verdict();
  end
endmodule
